/* File: verilog/flash_op_sequencer.v */
// Flash program/erase and integrity-check sequencer with APB registers
// How it works
// R1: program suspend sets completion flag within 11.5 us plus four clocks.
// R2: erase suspend sets completion flag within 20.8 us plus four clocks.
// R3: clearing suspend with high voltage enabled resumes; flag drops within 100 ns.
// R4: rising high-voltage enable starts operation and clears completion flag at once.
// R5: falling high-voltage enable aborts; flag set within 20.8 us plus four clocks.
// R6: after low-power exit, operations wait 45 us plus seven clocks recovery.
// R7: rising check enable starts a check and clears check-done at once.
// R8: resuming a suspended or breakpointed check clears check-done at once.
// R9: dropping check enable aborts integrity check; done within 80 ns plus 15 clocks.
// R10: check suspend on integrity check sets done within 80 ns plus 15 clocks.
// R11: dropping check enable aborts margin read; done between 10.36 and 20.42 us.
// R12: check suspend on margin read sets done between 10.36 and 20.42 us.
// R13: 16 KB integrity check takes 512 reads of nread clocks each.
// R14: software polls completion flags before changing controls again.
`timescale 1ns/100ps
`include "flash_seq_regs.vh"
module flash_op_sequencer (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire low_power_in,
    input wire pe_array_finished,
    input wire ai_mismatch,
    output wire hv_active,
    output wire pe_erase,
    output wire ai_read,
    output wire [8:0] ai_addr,
    output wire irq
);
    localparam integer RCV_I = `FS_RCV_CYC;
    localparam [11:0] RCV_CYC = RCV_I[11:0];
    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_CTRL = 3'h1;
    localparam [2:0] SEL_UT0 = 3'h2;
    localparam [2:0] SEL_STAT = 3'h3;
    localparam [2:0] SEL_MASK = 3'h4;

    // Control bits of the flash control register
    reg ehv_r;
    reg psus_r;
    reg esus_r;
    reg erase_r;
    // Control bits of the user test register
    reg aie_r;
    reg integrity_check_suspend_bit_r;
    reg integrity_breakpoint_disable_r;
    reg mr_r;
    reg [3:0] nread_r;
    // Interrupt status and mask
    reg [2:0] irq_stat_r;
    reg [2:0] irq_mask_r;
    // Low-power recovery
    reg lp_meta_r;
    reg lp_sync_r;
    reg lp_q_r;
    reg [11:0] rcv_cnt_r;
    reg rcv_busy_r;
    // Edge history for interrupt events
    reg done_q_r;
    reg aid_q_r;

    wire op_done;
    wire integrity_check_done_flag;
    reg [2:0] sel;
    reg ehv_nxt;
    reg psus_nxt;
    reg esus_nxt;
    reg erase_nxt;
    reg aie_nxt;
    reg integrity_check_suspend_bit_nxt;
    reg integrity_breakpoint_disable_nxt;
    reg mr_nxt;
    reg [3:0] nread_nxt;
    reg [2:0] irq_stat_nxt;
    reg [2:0] irq_mask_nxt;
    reg [31:0] rdata_nxt;

    function [2:0] decode;
        input [11:0] a;
        begin
            if (a == `FS_OFS_CTRL) begin
                decode = SEL_CTRL;
            end else if (a == `FS_OFS_UT0) begin
                decode = SEL_UT0;
            end else if (a == `FS_OFS_IRQ_STAT) begin
                decode = SEL_STAT;
            end else if (a == `FS_OFS_IRQ_MASK) begin
                decode = SEL_MASK;
            end else begin
                decode = SEL_NONE;
            end
        end
    endfunction

    // Zero wait states: read data is loaded during the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && (decode(paddr) == SEL_NONE);

    wire wr_en = psel && penable && pwrite;
    wire rd_setup = psel && !penable && !pwrite;
    // Edge flop covers the cycle before the counter starts, so no start slips in
    wire recovering = lp_sync_r || lp_q_r || rcv_busy_r;

    // Pin is asynchronous to clk, so two flops before use
    always @(posedge clk) begin
        if (sys_rst) begin
            lp_meta_r <= 1'b0;
            lp_sync_r <= 1'b0;
        end else begin
            lp_meta_r <= low_power_in;
            lp_sync_r <= lp_meta_r;
        end
    end

    // Recovery window runs from the low-power exit edge
    always @(posedge clk) begin
        if (sys_rst) begin
            lp_q_r <= 1'b0;
            rcv_cnt_r <= 12'h000;
            rcv_busy_r <= 1'b0;
        end else begin
            lp_q_r <= lp_sync_r;
            if (lp_q_r && !lp_sync_r) begin
                rcv_cnt_r <= RCV_CYC - 12'h001; // R6
                rcv_busy_r <= 1'b1;
            end else if (rcv_busy_r) begin
                if (rcv_cnt_r == 12'h000) begin
                    rcv_busy_r <= 1'b0;
                end else begin
                    rcv_cnt_r <= rcv_cnt_r - 12'h001;
                end
            end
        end
    end

    // Next values of the control bits; engines see them in the write cycle
    always @* begin
        sel = decode(paddr);
        ehv_nxt = ehv_r;
        psus_nxt = psus_r;
        esus_nxt = esus_r;
        erase_nxt = erase_r;
        aie_nxt = aie_r;
        integrity_check_suspend_bit_nxt = integrity_check_suspend_bit_r;
        integrity_breakpoint_disable_nxt = integrity_breakpoint_disable_r;
        mr_nxt = mr_r;
        nread_nxt = nread_r;
        irq_mask_nxt = irq_mask_r;
        irq_stat_nxt = irq_stat_r;
        if (wr_en && sel == SEL_CTRL) begin
            // A start is refused while the array is still recovering
            ehv_nxt = pwdata[`FS_CTRL_EHV] && (ehv_r || !recovering); // R6
            psus_nxt = pwdata[`FS_CTRL_PSUS];
            esus_nxt = pwdata[`FS_CTRL_ESUS];
            // Operation type is frozen while high voltage is on
            if (!ehv_r) begin
                erase_nxt = pwdata[`FS_CTRL_ERASE];
            end
        end else if (wr_en && sel == SEL_UT0) begin
            aie_nxt = pwdata[`FS_UT0_AIE] && (aie_r || !recovering); // R6
            integrity_check_suspend_bit_nxt = pwdata[`FS_UT0_INTEGRITY_CHECK_SUSPEND_BIT];
            integrity_breakpoint_disable_nxt = pwdata[`FS_UT0_INTEGRITY_BREAKPOINT_DISABLE];
            if (!aie_r) begin
                mr_nxt = pwdata[`FS_UT0_MR];
                nread_nxt = pwdata[`FS_UT0_NREAD_HI:`FS_UT0_NREAD_LO];
            end
        end else if (wr_en && sel == SEL_MASK) begin
            irq_mask_nxt = pwdata[2:0];
        end
        if (wr_en && sel == SEL_STAT) begin
            irq_stat_nxt = irq_stat_nxt & ~pwdata[2:0];
        end
        // Set after clear so an event in the clearing cycle survives
        if (op_done && !done_q_r) begin
            irq_stat_nxt[`FS_IRQ_OPDONE] = 1'b1;
        end
        if (integrity_check_done_flag && !aid_q_r) begin
            irq_stat_nxt[`FS_IRQ_CHKDONE] = 1'b1;
        end
        if (rcv_busy_r && rcv_cnt_r == 12'h000) begin
            irq_stat_nxt[`FS_IRQ_RCVDONE] = 1'b1;
        end
    end

    // Read multiplexer; unmapped reads return zero
    always @* begin
        rdata_nxt = 32'h00000000;
        if (sel == SEL_CTRL) begin
            rdata_nxt[`FS_CTRL_EHV] = ehv_r;
            rdata_nxt[`FS_CTRL_PSUS] = psus_r;
            rdata_nxt[`FS_CTRL_ESUS] = esus_r;
            rdata_nxt[`FS_CTRL_ERASE] = erase_r;
            rdata_nxt[`FS_CTRL_DONE] = op_done;
            rdata_nxt[`FS_CTRL_RCV] = recovering;
        end else if (sel == SEL_UT0) begin
            rdata_nxt[`FS_UT0_AIE] = aie_r;
            rdata_nxt[`FS_UT0_INTEGRITY_CHECK_SUSPEND_BIT] = integrity_check_suspend_bit_r;
            rdata_nxt[`FS_UT0_INTEGRITY_BREAKPOINT_DISABLE] = integrity_breakpoint_disable_r;
            rdata_nxt[`FS_UT0_MR] = mr_r;
            rdata_nxt[`FS_UT0_NREAD_HI:`FS_UT0_NREAD_LO] = nread_r;
            rdata_nxt[`FS_UT0_AID] = integrity_check_done_flag;
        end else if (sel == SEL_STAT) begin
            rdata_nxt[2:0] = irq_stat_r;
        end else if (sel == SEL_MASK) begin
            rdata_nxt[2:0] = irq_mask_r;
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            {erase_r, esus_r, psus_r, ehv_r} <= `FS_CTRL_RST;
            {nread_r, mr_r, integrity_breakpoint_disable_r, integrity_check_suspend_bit_r, aie_r} <= `FS_UT0_RST;
            irq_stat_r <= `FS_IRQ_RST;
            irq_mask_r <= `FS_IRQ_RST;
            done_q_r <= 1'b1;
            aid_q_r <= 1'b1;
            prdata <= 32'h00000000;
        end else begin
            ehv_r <= ehv_nxt;
            psus_r <= psus_nxt;
            esus_r <= esus_nxt;
            erase_r <= erase_nxt;
            aie_r <= aie_nxt;
            integrity_check_suspend_bit_r <= integrity_check_suspend_bit_nxt;
            integrity_breakpoint_disable_r <= integrity_breakpoint_disable_nxt;
            mr_r <= mr_nxt;
            nread_r <= nread_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            done_q_r <= op_done;
            aid_q_r <= integrity_check_done_flag;
            if (rd_setup) begin
                prdata <= rdata_nxt;
            end
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);
    assign pe_erase = erase_r;

    // Completion flags clear at the same edge as the control write
    pe_engine u_pe (
        .clk(clk),
        .sys_rst(sys_rst),
        .ehv_nxt(ehv_nxt),
        .psus_nxt(psus_nxt),
        .esus_nxt(esus_nxt),
        .erase_nxt(erase_nxt),
        .array_finished(pe_array_finished),
        .done_r(op_done),
        .hv_active(hv_active)
    );

    integrity_checker u_chk (
        .clk(clk),
        .sys_rst(sys_rst),
        .aie_nxt(aie_nxt),
        .integrity_check_suspend_bit_nxt(integrity_check_suspend_bit_nxt),
        .integrity_breakpoint_disable_nxt(integrity_breakpoint_disable_nxt),
        .mode_mr(mr_r),
        .nread(nread_r),
        .mismatch(ai_mismatch),
        .aid_r(integrity_check_done_flag),
        .read_r(ai_read),
        .addr_r(ai_addr)
    );
endmodule

/* File: include/flash_seq_regs.vh */
// Register map, field positions, reset values and timing counts of the flash sequencer
`ifndef FLASH_SEQ_REGS_VH
`define FLASH_SEQ_REGS_VH
`define FS_OFS_CTRL 12'h000
`define FS_OFS_UT0 12'h004
`define FS_OFS_IRQ_STAT 12'h008
`define FS_OFS_IRQ_MASK 12'h00C
`define FS_CTRL_EHV 0
`define FS_CTRL_PSUS 1
`define FS_CTRL_ESUS 2
`define FS_CTRL_ERASE 3
`define FS_CTRL_DONE 8
`define FS_CTRL_RCV 9
`define FS_UT0_AIE 0
`define FS_UT0_INTEGRITY_CHECK_SUSPEND_BIT 1
`define FS_UT0_INTEGRITY_BREAKPOINT_DISABLE 2
`define FS_UT0_MR 3
`define FS_UT0_NREAD_LO 4
`define FS_UT0_NREAD_HI 7
`define FS_UT0_AID 8
`define FS_IRQ_OPDONE 0
`define FS_IRQ_CHKDONE 1
`define FS_IRQ_RCVDONE 2
`define FS_CTRL_RST 4'h0
`define FS_UT0_RST 8'h10
`define FS_IRQ_RST 3'h0
`define FS_CLK_NS 20
`define FS_PSUS_TYP_NS 9400
`define FS_ESUS_TYP_NS 16000
`define FS_ABORT_TYP_NS 16000
`define FS_RCV_MAX_NS 45000
`define FS_AISTOP_MAX_NS 80
`define FS_MRSTOP_MIN_NS 10360
`define FS_PSUS_CYC ((`FS_PSUS_TYP_NS / `FS_CLK_NS) + 4)
`define FS_ESUS_CYC ((`FS_ESUS_TYP_NS / `FS_CLK_NS) + 4)
`define FS_ABORT_CYC ((`FS_ABORT_TYP_NS / `FS_CLK_NS) + 4)
`define FS_RCV_CYC ((`FS_RCV_MAX_NS / `FS_CLK_NS) + 7)
`define FS_AISTOP_CYC ((`FS_AISTOP_MAX_NS / `FS_CLK_NS) + 15)
`define FS_MRSTOP_CYC (((`FS_MRSTOP_MIN_NS + `FS_CLK_NS - 1) / `FS_CLK_NS) + 4)
`define FS_AI_READS 512
`endif

/* File: verilog/pe_engine.v */
// Program/erase sequencer: start, suspend, resume, abort and completion flag
`timescale 1ns/100ps
`include "flash_seq_regs.vh"
module pe_engine (
    input wire clk,
    input wire sys_rst,
    input wire ehv_nxt,
    input wire psus_nxt,
    input wire esus_nxt,
    input wire erase_nxt,
    input wire array_finished,
    output reg done_r,
    output wire hv_active
);
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_RUN = 3'h1;
    localparam [2:0] S_SUSW = 3'h2;
    localparam [2:0] S_SUSP = 3'h3;
    localparam [2:0] S_ABW = 3'h4;
    localparam integer PSUS_I = `FS_PSUS_CYC;
    localparam integer ESUS_I = `FS_ESUS_CYC;
    localparam integer ABORT_I = `FS_ABORT_CYC;
    localparam [11:0] PSUS_CYC = PSUS_I[11:0];
    localparam [11:0] ESUS_CYC = ESUS_I[11:0];
    localparam [11:0] ABORT_CYC = ABORT_I[11:0];
    reg [2:0] state_r;
    reg ehv_q_r;
    reg sus_q_r;
    reg [11:0] cnt_r;
    wire sus_nxt = erase_nxt ? esus_nxt : psus_nxt;
    assign hv_active = (state_r == S_RUN);
    always @(posedge clk) begin
        if (sys_rst) begin
            state_r <= S_IDLE;
            ehv_q_r <= 1'b0;
            sus_q_r <= 1'b0;
            cnt_r <= 12'h000;
            done_r <= 1'b1;
        end else begin
            ehv_q_r <= ehv_nxt;
            sus_q_r <= sus_nxt;
            case (state_r)
                S_IDLE: begin
                    if (ehv_nxt && !ehv_q_r) begin
                        done_r <= 1'b0; // R4
                        state_r <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (!ehv_nxt) begin
                        cnt_r <= ABORT_CYC - 12'h001; // R5
                        state_r <= S_ABW;
                    end else if (sus_nxt && !sus_q_r) begin
                        cnt_r <= (erase_nxt ? ESUS_CYC : PSUS_CYC) - 12'h001; // R1 R2
                        state_r <= S_SUSW;
                    end else if (array_finished) begin
                        done_r <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                S_SUSW, S_ABW: begin
                    if (cnt_r == 12'h000) begin
                        done_r <= 1'b1; // R1 R2 R5
                        state_r <= (state_r == S_ABW) ? S_IDLE : S_SUSP;
                    end else begin
                        cnt_r <= cnt_r - 12'h001;
                    end
                end
                S_SUSP: begin
                    if (!ehv_nxt) begin
                        state_r <= S_IDLE;
                    end else if (!sus_nxt) begin
                        done_r <= 1'b0; // R3
                        state_r <= S_RUN;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule

/* File: verilog/integrity_checker.v */
// Margin read and array integrity checker with suspend, breakpoint and abort
`timescale 1ns/100ps
`include "flash_seq_regs.vh"
module integrity_checker (
    input wire clk,
    input wire sys_rst,
    input wire aie_nxt,
    input wire integrity_check_suspend_bit_nxt,
    input wire integrity_breakpoint_disable_nxt,
    input wire mode_mr,
    input wire [3:0] nread,
    input wire mismatch,
    output reg aid_r,
    output reg read_r,
    output reg [8:0] addr_r
);
    localparam [1:0] C_IDLE = 2'h0;
    localparam [1:0] C_RUN = 2'h1;
    localparam [1:0] C_STW = 2'h2;
    localparam [1:0] C_PAUSE = 2'h3;
    localparam integer AISTOP_I = `FS_AISTOP_CYC;
    localparam integer MRSTOP_I = `FS_MRSTOP_CYC;
    localparam integer LAST_I = `FS_AI_READS - 1;
    localparam [9:0] AISTOP_CYC = AISTOP_I[9:0];
    localparam [9:0] MRSTOP_CYC = MRSTOP_I[9:0];
    localparam [8:0] LAST_ADDR = LAST_I[8:0];
    reg [1:0] state_r;
    reg aie_q_r;
    reg sus_q_r;
    reg bp_q_r;
    reg abort_r;
    reg [9:0] cnt_r;
    reg [3:0] rd_cnt_r;
    // Next read position; addr_r shows the address of the read just issued
    reg [8:0] pos_r;
    wire [3:0] nread_eff = (nread == 4'h0) ? 4'h1 : nread;
    wire read_now = (rd_cnt_r == nread_eff - 4'h1);
    always @(posedge clk) begin
        if (sys_rst) begin
            state_r <= C_IDLE;
            aie_q_r <= 1'b0;
            sus_q_r <= 1'b0;
            bp_q_r <= 1'b0;
            abort_r <= 1'b0;
            cnt_r <= 10'h000;
            rd_cnt_r <= 4'h0;
            aid_r <= 1'b1;
            read_r <= 1'b0;
            addr_r <= 9'h000;
            pos_r <= 9'h000;
        end else begin
            aie_q_r <= aie_nxt;
            sus_q_r <= integrity_check_suspend_bit_nxt;
            bp_q_r <= integrity_breakpoint_disable_nxt;
            read_r <= 1'b0;
            case (state_r)
                C_IDLE: begin
                    if (aie_nxt && !aie_q_r) begin
                        aid_r <= 1'b0; // R7
                        pos_r <= 9'h000;
                        rd_cnt_r <= 4'h0;
                        state_r <= C_RUN;
                    end
                end
                C_RUN: begin
                    if (!aie_nxt || (integrity_check_suspend_bit_nxt && !sus_q_r)) begin
                        abort_r <= !aie_nxt;
                        cnt_r <= (mode_mr ? MRSTOP_CYC : AISTOP_CYC) - 10'h001; // R9 R10 R11 R12
                        state_r <= C_STW;
                    end else if (mismatch && integrity_breakpoint_disable_nxt) begin
                        aid_r <= 1'b1;
                        state_r <= C_PAUSE;
                    end else if (read_now) begin
                        read_r <= 1'b1; // R13
                        rd_cnt_r <= 4'h0;
                        addr_r <= pos_r;
                        if (pos_r == LAST_ADDR) begin
                            aid_r <= 1'b1;
                            state_r <= C_IDLE;
                        end else begin
                            pos_r <= pos_r + 9'h001;
                        end
                    end else begin
                        rd_cnt_r <= rd_cnt_r + 4'h1;
                    end
                end
                C_STW: begin
                    if (cnt_r == 10'h000) begin
                        aid_r <= 1'b1; // R9 R10 R11 R12
                        state_r <= abort_r ? C_IDLE : C_PAUSE;
                    end else begin
                        cnt_r <= cnt_r - 10'h001;
                    end
                end
                C_PAUSE: begin
                    if (!aie_nxt) begin
                        state_r <= C_IDLE;
                    end else if ((sus_q_r && !integrity_check_suspend_bit_nxt) || (bp_q_r && !integrity_breakpoint_disable_nxt)) begin
                        aid_r <= 1'b0; // R8
                        rd_cnt_r <= 4'h0;
                        state_r <= C_RUN;
                    end
                end
                default: state_r <= C_IDLE;
            endcase
        end
    end
endmodule

/* File: sim/flash_op_sequencer_assertions.sv */
// Port-level checker for the flash sequencer
`timescale 1ns/100ps
`include "flash_seq_regs.vh"
module flash_op_sequencer_checker (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire low_power_in,
    input wire pe_array_finished,
    input wire ai_mismatch,
    input wire hv_active,
    input wire pe_erase,
    input wire ai_read,
    input wire [8:0] ai_addr,
    input wire irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    wire acc = psel && penable;
    wire ctrl_wr = acc && pwrite && paddr == `FS_OFS_CTRL;
    wire mapped = paddr == `FS_OFS_CTRL || paddr == `FS_OFS_UT0 ||
        paddr == `FS_OFS_IRQ_STAT || paddr == `FS_OFS_IRQ_MASK;
    // Zero wait state slave
    a_ready_high: assert property (pready) else $error("pready low");
    a_slverr_map: assert property (pslverr == (acc && !mapped)) else $error("pslverr wrong");
    a_reset_clear: assert property ($fell(sys_rst) |-> prdata == 32'h0 && !hv_active &&
        !pe_erase && !ai_read && ai_addr == 9'h000 && !irq) else $error("bad reset state");
    a_abort_stop: assert property (hv_active && ctrl_wr && !pwdata[`FS_CTRL_EHV] |=> !hv_active)
        else $error("abort did not stop run");
    a_suspend_stop: assert property (hv_active && ctrl_wr && pwdata[`FS_CTRL_EHV] &&
        (pe_erase ? pwdata[`FS_CTRL_ESUS] : pwdata[`FS_CTRL_PSUS]) |=> !hv_active)
        else $error("suspend did not stop run");
    a_finish_stop: assert property (hv_active && pe_array_finished |=> !hv_active)
        else $error("finish did not stop run");
    // Erase select must not flip under a running operation
    a_erase_hold: assert property (hv_active && $past(hv_active) |-> $stable(pe_erase))
        else $error("erase select changed in run");
    a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("prdata changed without read");
    a_read_step: assert property (ai_read ##1 ai_read |-> ai_addr == $past(ai_addr) + 9'h001)
        else $error("check address did not step");
    cover property ($rose(hv_active));
    cover property (ai_read && ai_addr == 9'h1FF);
    cover property ($rose(irq));
    cover property (pslverr);
endmodule

/* File: sim/flash_op_sequencer_tb.sv */
// Self-checking bench for the flash sequencer
`timescale 1ns/100ps
`include "flash_seq_regs.vh"
module flash_op_sequencer_tb;
    reg clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, slv = 0;
    reg low_power_in = 0, pe_array_finished = 0, ai_mismatch = 0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, d;
    reg [8:0] la;
    wire [31:0] prdata;
    wire pready, pslverr, hv_active, pe_erase, ai_read, irq;
    wire [8:0] ai_addr;
    integer cyc = 0, te = 0, ts = 0, tf, n0, nrd = 0, last = 0, err_total = 0, compares = 0;
    flash_op_sequencer flash_op_sequencer_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .low_power_in(low_power_in),
        .pe_array_finished(pe_array_finished), .ai_mismatch(ai_mismatch),
        .hv_active(hv_active), .pe_erase(pe_erase), .ai_read(ai_read), .ai_addr(ai_addr),
        .irq(irq));
    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // Pulses show up one edge after they are launched
    always @(posedge clk) if (ai_read === 1'b1) begin
        nrd <= nrd + 1;
        last <= cyc;
        la <= ai_addr;
    end
    task conclude;
        begin
            if (err_total == 0 && compares > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] s, input [31:0] e);
        begin
            compares = compares + 1;
            if (s !== e) begin
                err_total = err_total + 1;
                $display("MISMATCH %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task wr(input [11:0] a, input [31:0] v);
        begin
            @(posedge clk);
            psel <= 1;
            pwrite <= 1;
            paddr <= a;
            pwdata <= v;
            @(posedge clk);
            penable <= 1;
            @(posedge clk);
            while (pready !== 1'b1) @(posedge clk);
            te = cyc;
            psel <= 0;
            penable <= 0;
        end
    endtask
    task rd(input [11:0] a);
        begin
            @(posedge clk);
            psel <= 1;
            pwrite <= 0;
            paddr <= a;
            @(posedge clk);
            ts = cyc;
            penable <= 1;
            @(posedge clk);
            while (pready !== 1'b1) @(posedge clk);
            d = prdata;
            slv = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    // Polls the flag rather than trusting a fixed delay
    task poll(input [11:0] a, input integer b, v, lo, hi, input string nm);
        integer n;
        begin
            n = 0;
            rd(a);
            while (d[b] !== v[0] && n < hi) begin
                rd(a);
                n = n + 1;
            end
            // Flag read at a setup edge was set at the edge before it
            chk(nm, (ts - te - 1) >= lo && (ts - te - 1) <= hi, 1);
        end
    endtask
    // Suspend, resume, then abort one check; m selects margin read
    task stop_seq(input [31:0] m, input integer lo, hi);
        begin
            wr(`FS_OFS_UT0, 32'h20 | m);
            wr(`FS_OFS_UT0, 32'h21 | m);
            repeat (40) @(posedge clk);
            wr(`FS_OFS_UT0, 32'h23 | m);
            poll(`FS_OFS_UT0, 8, 1, lo, hi, "suspend_lat");
            wr(`FS_OFS_UT0, 32'h21 | m);
            rd(`FS_OFS_UT0);
            chk("aid_resume", d[8], 0);
            wr(`FS_OFS_UT0, 32'h20 | m);
            poll(`FS_OFS_UT0, 8, 1, lo, hi, "abort_lat");
        end
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        err_total = err_total + 1;
        conclude;
    end
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 0;
        rd(`FS_OFS_CTRL);
        chk("ctrl_rst", d, 32'h100);
        rd(`FS_OFS_UT0);
        chk("ut0_rst", d, 32'h110);
        rd(`FS_OFS_IRQ_MASK);
        chk("mask_rst", d, 32'h0);
        rd(12'h010);
        chk("unmapped", d, 32'h0);
        chk("unmapped_err", slv, 1);
        wr(`FS_OFS_CTRL, 32'h1);
        rd(`FS_OFS_CTRL);
        chk("done_start", d[8], 0);
        chk("hv_run", hv_active, 1);
        wr(`FS_OFS_CTRL, 32'h3);
        poll(`FS_OFS_CTRL, 8, 1, 0, 579, "psus_lat");
        chk("hv_susp", hv_active, 0);
        wr(`FS_OFS_CTRL, 32'h1);
        rd(`FS_OFS_CTRL);
        chk("done_resume", d[8], 0);
        @(posedge clk) pe_array_finished <= 1;
        @(posedge clk) pe_array_finished <= 0;
        rd(`FS_OFS_CTRL);
        chk("done_finish", d[8], 1);
        wr(`FS_OFS_CTRL, 32'h0);
        wr(`FS_OFS_CTRL, 32'h8);
        wr(`FS_OFS_CTRL, 32'h9);
        rd(`FS_OFS_CTRL);
        chk("done_erase", d[8], 0);
        chk("erase_sel", pe_erase, 1);
        wr(`FS_OFS_CTRL, 32'hD);
        poll(`FS_OFS_CTRL, 8, 1, 0, 1044, "esus_lat");
        wr(`FS_OFS_CTRL, 32'h1);
        rd(`FS_OFS_CTRL);
        chk("done_eresume", d[8], 0);
        chk("erase_kept", pe_erase, 1);
        wr(`FS_OFS_CTRL, 32'h0);
        poll(`FS_OFS_CTRL, 8, 1, 0, 1044, "abort_lat");
        wr(`FS_OFS_UT0, 32'h10);
        n0 = nrd;
        wr(`FS_OFS_UT0, 32'h11);
        rd(`FS_OFS_UT0);
        chk("aid_start", d[8], 0);
        poll(`FS_OFS_UT0, 8, 1, 0, 600, "check_end");
        chk("check_reads", nrd - n0, 512);
        chk("check_time", (last - te) <= 513, 1);
        chk("check_last", la, 9'h1FF);
        wr(`FS_OFS_UT0, 32'h10);
        stop_seq(32'h0, 0, 19);
        stop_seq(32'h8, 522, 1025);
        wr(`FS_OFS_UT0, 32'h24);
        wr(`FS_OFS_UT0, 32'h25);
        ai_mismatch <= 1;
        poll(`FS_OFS_UT0, 8, 1, 0, 50, "bp_stop");
        ai_mismatch <= 0;
        wr(`FS_OFS_UT0, 32'h21);
        rd(`FS_OFS_UT0);
        chk("aid_bp_resume", d[8], 0);
        wr(`FS_OFS_UT0, 32'h20);
        poll(`FS_OFS_UT0, 8, 1, 0, 19, "bp_abort");
        rd(`FS_OFS_IRQ_STAT);
        chk("stat_events", d, 32'h3);
        wr(`FS_OFS_IRQ_MASK, 32'h1);
        @(negedge clk) chk("irq_on", irq, 1);
        wr(`FS_OFS_IRQ_MASK, 32'h0);
        @(negedge clk) chk("irq_masked", irq, 0);
        wr(`FS_OFS_IRQ_STAT, 32'h3);
        rd(`FS_OFS_IRQ_STAT);
        chk("stat_clear", d, 32'h0);
        wr(`FS_OFS_IRQ_MASK, 32'h7);
        @(negedge clk) chk("irq_idle", irq, 0);
        @(posedge clk) low_power_in <= 1;
        repeat (5) @(posedge clk);
        low_power_in <= 0;
        tf = cyc;
        wr(`FS_OFS_CTRL, 32'h1);
        rd(`FS_OFS_CTRL);
        chk("rcv_refuse", d, 32'h300);
        te = tf;
        // Limit widened by the input sync and one poll step
        poll(`FS_OFS_CTRL, 9, 0, 0, 2262, "rcv_len");
        @(negedge clk) chk("irq_rcv", irq, 1);
        rd(`FS_OFS_IRQ_STAT);
        chk("stat_rcv", d, 32'h4);
        wr(`FS_OFS_CTRL, 32'h1);
        rd(`FS_OFS_CTRL);
        chk("rcv_start", hv_active, 1);
        wr(`FS_OFS_CTRL, 32'h0);
        conclude;
    end
endmodule
bind flash_op_sequencer flash_op_sequencer_checker flash_op_sequencer_checker_inst (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_power_in(low_power_in), .pe_array_finished(pe_array_finished),
    .ai_mismatch(ai_mismatch), .hv_active(hv_active), .pe_erase(pe_erase),
    .ai_read(ai_read), .ai_addr(ai_addr), .irq(irq));
